// ---- core_model.sv ----
// Core side: takes a vector, runs a handler of short or long length, then returns.
module core_model (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic entry_valid,
    input  wire logic return_done,
    input  wire logic slow,
    output logic      core_ready,
    output logic      return_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    logic       serving;
    // Ready only between handlers, so a second accept cannot overlap a return.
    assign core_ready = !serving;
    // The end of handler is a one-cycle pulse sent when a count of 1, or 9 with slow set, runs out after entry.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            serving <= 1'h0;
            wait_cnt <= 4'h0;
            return_req <= 1'h0;
        end else begin
            return_req <= 1'h0;
            if (entry_valid) begin
                serving <= 1'h1;
                wait_cnt <= slow ? 4'h9 : 4'h1;
            end else if (serving && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
                return_req <= (wait_cnt == 4'h1);
            end
            if (return_done) serving <= 1'h0;
        end
    end
endmodule

// ---- intc_monitor.sv ----
module intc_monitor
    import intc_pkg::*;
#(
    parameter int N_IRQ = NUM_IRQ
) (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic [N_IRQ-1:0]    flag_clear,
    input wire logic [LVL_W-1:0]    cpu_priority_level,
    input wire logic                core_ready,
    input wire logic                return_req,
    input wire logic                core_irq,
    input wire logic                entry_valid,
    input wire logic [ADDR_W-1:0]   entry_addr,
    input wire logic                return_done,
    input wire logic                busy,
    input wire logic [ADDR_W-1:0]   program_counter,
    input wire logic [N_IRQ-1:0]    request_flag_regs,
    input wire logic [NUM_TRAP-1:0] trap_flags,
    input wire logic [VEC_W-1:0]    accepted_vector_number,
    input wire logic [ADDR_W-1:0]   pending_table_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Latency checks tie each pulse to its cause so a drifting counter shows up.
    // The entry pulse is registered at the fourth edge after accept, so it is sampled at the fifth.
    entry_latency_a: assert property (core_irq && core_ready |-> ##5 entry_valid)
        else $error("entry late");
    return_latency_a: assert property (return_done |-> $past(return_req, 4))
        else $error("return late");
    entry_jump_a: assert property (entry_valid |-> program_counter == entry_addr)
        else $error("pc off");
    single_request_a: assert property (core_irq && core_ready |=> busy && !core_irq)
        else $error("irq while busy");
    vector_latch_a: assert property (core_irq && core_ready |=>
        accepted_vector_number == VEC_W'(($past(pending_table_addr) - TABLE_BASE) >> 1))
        else $error("vector");
    user_block_a: assert property (cpu_priority_level[3] && trap_flags == '0 |-> !core_irq)
        else $error("blocked");
    table_place_a: assert property (
        core_irq |-> !pending_table_addr[0] && pending_table_addr >= TABLE_BASE) else $error("table address");
    flag_sticky_a: assert property (
        1'h1 |=> ($past(request_flag_regs & ~flag_clear) & ~request_flag_regs) == '0) else $error("flag dropped");
    reserved_quiet_a: assert property ((request_flag_regs & ~IRQ_IMPL_MASK) == '0)
        else $error("reserved");
    // Main scenarios: an accept, a finished return and a trap pending over a high level.
    cover property (core_irq && core_ready);
    cover property (return_done);
    cover property (trap_flags != '0 && cpu_priority_level[3]);
endmodule

bind vectored_priority_interrupt_controller intc_monitor #(.N_IRQ(N_IRQ)) mon (.clk_sys, .rst, .flag_clear,
    .cpu_priority_level, .core_ready, .return_req, .core_irq, .entry_valid, .entry_addr, .return_done, .busy,
    .program_counter, .request_flag_regs, .trap_flags, .accepted_vector_number, .pending_table_addr);

// ---- intc_pkg.sv ----
package intc_pkg;
    // Source counts and widths.
    localparam int NUM_IRQ       = 118;
    localparam int NUM_TRAP      = 8;
    localparam int PRI_W         = 3;
    localparam int LVL_W         = 4;
    localparam int VEC_W         = 8;
    localparam int ADDR_W        = 24;
    localparam int IRQ_IDX_W     = 7;
    // Vector numbering and table placement.
    localparam logic [ADDR_W-1:0] TABLE_BASE   = 24'h000004;
    localparam logic [ADDR_W-1:0] RESET_ADDR   = 24'h000000;
    localparam logic [VEC_W-1:0]  IRQ_VEC_BASE = 8'h08;
    localparam int EXT_IRQ_ZERO_NUM  = 0;
    localparam int TIMER_ONE_IRQ_NUM = 3;
    // Fixed latencies of entry and return, in cycles.
    localparam int ENTRY_CYCLES  = 4;
    localparam int RETURN_CYCLES = 3;
    localparam int CNT_W         = 3;
    // Priority register pitch: four sources per sixteen-bit word.
    localparam int PRI_FIELD_PITCH = 4;
    // Implemented request numbers, one bit per request number, set where the request is implemented.
    localparam logic [NUM_IRQ-1:0] IRQ_IMPL_MASK = {
        {(NUM_IRQ-97){1'b0}},
        {3{1'b1}},                  // 94..96
        {(94-78){1'b0}},
        1'b1,                       // 77
        {(77-71){1'b0}},
        1'b1,                       // 70
        2'b00,
        {3{1'b1}},                  // 65..67
        {(65-59){1'b0}},
        2'b11,                      // 57..58
        {(57-51){1'b0}},
        2'b11,                      // 49..50
        {(49-39){1'b0}},
        {15{1'b1}},                 // 24..38
        3'b000,
        {5{1'b1}},                  // 16..20
        1'b0,
        {15{1'b1}}                  // 0..14
    };
    localparam logic [LVL_W-1:0] LVL_RESET = 4'h0;
endpackage

// ---- vector_table.sv ----
// Handler address store, one word per vector, with registered read data.
module vector_table
    import intc_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              wr_en,
    input  wire logic [AW-1:0]     wr_index,
    input  wire logic [ADDR_W-1:0] wr_data,
    input  wire logic [AW-1:0]     rd_index,
    output logic      [ADDR_W-1:0] rd_data
);
    // A depth beyond the index range would leave entries that can never be read.
    if (DEPTH > (1 << AW)) begin : g_depth_check
        $error("vector_table depth exceeds index width");
    end

    logic [ADDR_W-1:0] mem [DEPTH];

    // Software loads entries; read data is registered so entry timing is fixed.
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
        rd_data <= mem[rd_index];
    end
endmodule

// ---- vectored_priority_interrupt_controller.sv ----
// Contract
// [RULE1] All request lines merge into one request to the core.
// [RULE2] Each user source has one of eight priority levels.
// [RULE3] Equal priorities resolve by fixed natural order, not arrival time.
// [RULE4] Entry and return take a constant number of cycles.
// [RULE5] Up to eight traps and software traps exist beside user sources.
// [RULE6] The vector table starts at word address 000004h, one vector per source.
// [RULE7] Seven non-maskable trap vectors and up to 114 interrupt vectors; the code has eight trap vectors (0 to 7) and 118 request numbers.
// [RULE8] Each vector holds a 24-bit handler address used as entry point.
// [RULE9] Lower vector number wins; vector 0 outranks all.
// [RULE10] Reset bypasses the controller, clears state, program counter goes to zero.
// [RULE11] Software should fill unused vectors with a reset-performing default handler.
// [RULE12] External interrupt zero is vector 8, request 0, address 0x000014.
// [RULE13] Timer one is vector 11, request 3, address 0x00001A.
// [RULE14] Flags set by sources stay set until software clears; each has an enable.
// [RULE15] On acceptance latch 8-bit vector number and 4-bit new level.
// [RULE16] Processor level is 4 bits; top bit set blocks all user interrupts.
// [RULE17] Request needs flag, enable, priority above current level; priority zero never.
// [RULE18] Table address is 0x000004 plus twice vector; reserved vectors never request.
module vectored_priority_interrupt_controller
    import intc_pkg::*;
#(
    parameter int N_IRQ  = NUM_IRQ,
    parameter int N_TRAP = NUM_TRAP
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [N_IRQ-1:0]      irq_event,
    input  wire logic [N_IRQ-1:0]      flag_clear,
    input  wire logic [N_IRQ-1:0]      enable_bits,
    input  wire logic [N_IRQ*PRI_W-1:0] source_priority_regs,
    input  wire logic [N_TRAP-1:0]     trap_event,
    input  wire logic [N_TRAP-1:0]     trap_clear,
    input  wire logic [LVL_W-1:0]      cpu_priority_level,
    input  wire logic                  core_ready,
    input  wire logic                  return_req,
    input  wire logic                  table_wr_en,
    input  wire logic [VEC_W-1:0]      table_wr_vector,
    input  wire logic [ADDR_W-1:0]     table_wr_addr,
    output logic                       core_irq,
    output logic                       entry_valid,
    output logic [ADDR_W-1:0]          entry_addr,
    output logic                       return_done,
    output logic                       busy,
    output logic [ADDR_W-1:0]          program_counter,
    output logic [N_IRQ-1:0]           request_flag_regs,
    output logic [N_TRAP-1:0]          trap_flags,
    output logic [VEC_W-1:0]           accepted_vector_number,
    output logic [LVL_W-1:0]           new_cpu_level,
    output logic [ADDR_W-1:0]          pending_table_addr
);
    // Refuse counts at elaboration: the reserved mask and trap order only cover the package sizes.
    if (N_IRQ > NUM_IRQ || N_IRQ < 1) begin : g_irq_count_check
        $error("unsupported source count");
    end
    if (N_TRAP > NUM_TRAP || N_TRAP < 1) begin : g_trap_count_check
        $error("unsupported trap count");
    end

    // One interrupt passes through entry, service and return before the next is taken.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ENTRY  = 2'b01,
        ST_SERVE  = 2'b10,
        ST_RETURN = 2'b11
    } phase_e;

    // Table address of a vector: base plus two words per vector.
    function automatic logic [ADDR_W-1:0] table_addr(input logic [VEC_W-1:0] vec);
        table_addr = TABLE_BASE + {{(ADDR_W-VEC_W-1){1'b0}}, vec, 1'b0};
    endfunction

    // Sequencer state, its cycle counter and the per-source qualification vectors.
    phase_e            phase;
    phase_e            next_phase;
    logic [CNT_W-1:0]  cnt;
    logic [N_IRQ-1:0]  eligible;
    logic [N_IRQ-1:0]  impl_mask;

    // Reserved request numbers have no flag at all, so they are cut at the flag input.
    // A stray event on such a line can therefore never reach arbitration.
    assign impl_mask = IRQ_IMPL_MASK[N_IRQ-1:0];

    // Flags are sticky; a set in the same cycle as a clear wins.
    // Losing an event to a racing software clear would drop a request silently.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            request_flag_regs <= '0;
            trap_flags        <= '0;
        end else begin
            request_flag_regs <= (irq_event | (request_flag_regs & ~flag_clear)) & impl_mask; // [RULE14] [RULE18]
            trap_flags        <= trap_event | (trap_flags & ~trap_clear); // [RULE5]
        end
    end

    // Each source is eligible only if flagged, enabled, implemented and above the core level.
    genvar g;
    generate
        for (g = 0; g < N_IRQ; g++) begin : g_elig
            logic [PRI_W-1:0] pri;
            assign pri = source_priority_regs[g*PRI_W +: PRI_W]; // [RULE2]
            assign eligible[g] = request_flag_regs[g] & enable_bits[g] & impl_mask[g]
                               & (pri != '0)
                               & ({1'b0, pri} > cpu_priority_level); // [RULE16] [RULE17]
        end
    endgenerate

    // Arbitration: traps first by natural order, then highest user priority,
    // ties going to the lowest request number. A reversed scan keeps the lowest.
    // Traps ignore the core level, so a raised level can never mask them.
    logic             any_trap;
    logic [VEC_W-1:0] trap_vec;
    logic             any_irq;
    logic [PRI_W-1:0] best_pri;
    logic [VEC_W-1:0] best_num;
    always_comb begin
        any_trap = 1'b0;
        trap_vec = '0;
        for (int t = N_TRAP - 1; t >= 0; t--) begin
            if (trap_flags[t]) begin
                any_trap = 1'b1;
                trap_vec = VEC_W'(t); // [RULE9]
            end
        end
        any_irq  = 1'b0;
        best_pri = '0;
        best_num = '0;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (eligible[i] && (!any_irq ||
                source_priority_regs[i*PRI_W +: PRI_W] >= best_pri)) begin // [RULE3]
                any_irq  = 1'b1;
                best_pri = source_priority_regs[i*PRI_W +: PRI_W];
                best_num = VEC_W'(i);
            end
        end
    end

    // Winner of this cycle. A trap reports level 15 so that nothing but another trap
    // could preempt it; core_irq is held low while a handler is in flight, which keeps
    // at most one request outstanding toward the core.
    logic             win_valid;
    logic [VEC_W-1:0] win_vec;
    logic [LVL_W-1:0] win_lvl;
    assign win_valid = any_trap | any_irq; // [RULE1]
    assign win_vec   = any_trap ? trap_vec : (best_num + IRQ_VEC_BASE); // [RULE12] [RULE13]
    assign win_lvl   = any_trap ? 4'hF : {1'b0, best_pri};
    assign core_irq  = win_valid & (phase == ST_IDLE);
    assign busy      = (phase != ST_IDLE);
    assign pending_table_addr = table_addr(win_vec); // [RULE18]

    // Handler address lookup; the registered read keeps entry latency fixed.
    // The table is indexed by the latched vector, so a later winner cannot disturb it.
    logic [ADDR_W-1:0] handler_addr;
    vector_table #(
        .DEPTH (1 << VEC_W),
        .AW    (VEC_W)
    ) u_table (
        .clk_sys  (clk_sys),
        .wr_en    (table_wr_en),
        .wr_index (table_wr_vector),
        .wr_data  (table_wr_addr),
        .rd_index (accepted_vector_number),
        .rd_data  (handler_addr)
    ); // [RULE6] [RULE7] [RULE8]

    // A request is taken only while idle and while the core says it can take one.
    // The winner of that very cycle is the one latched, whatever arrives later.
    logic accept;
    assign accept = (phase == ST_IDLE) & win_valid & core_ready;

    // Phase sequencing with fixed counts, independent of the source taken.
    always_comb begin
        next_phase = phase;
        unique case (phase)
            ST_IDLE:   if (accept) next_phase = ST_ENTRY;
            ST_ENTRY:  if (cnt == CNT_W'(ENTRY_CYCLES - 1)) next_phase = ST_SERVE; // [RULE4]
            ST_SERVE:  if (return_req) next_phase = ST_RETURN;
            ST_RETURN: if (cnt == CNT_W'(RETURN_CYCLES - 1)) next_phase = ST_IDLE; // [RULE4]
        endcase
    end

    // The counter restarts on every phase change, so entry and return each last a fixed count
    // no matter which source was taken or how long the handler ran.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase <= ST_IDLE;
            cnt   <= '0;
        end else begin
            phase <= next_phase;
            cnt   <= (next_phase != phase) ? '0 : cnt + 1'b1;
        end
    end

    // Latch the accepted vector and its level for software to read.
    // They hold until the next accept, so software may read them at any time in the handler.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            accepted_vector_number <= '0;
            new_cpu_level          <= LVL_RESET;
        end else if (accept) begin
            accepted_vector_number <= win_vec; // [RULE15]
            new_cpu_level          <= win_lvl; // [RULE15]
        end
    end

    // Program counter: zero from reset, the handler address at the end of entry.
    // Entry and return pulses are registered, so each stands for exactly one cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            program_counter <= RESET_ADDR; // [RULE10]
            entry_valid     <= 1'b0;
            entry_addr      <= RESET_ADDR;
            return_done     <= 1'b0;
        end else begin
            entry_valid <= (phase == ST_ENTRY) && (next_phase == ST_SERVE);
            return_done <= (phase == ST_RETURN) && (next_phase == ST_IDLE);
            if ((phase == ST_ENTRY) && (next_phase == ST_SERVE)) begin
                entry_addr      <= handler_addr; // [RULE8]
                program_counter <= handler_addr;
            end
        end
    end
endmodule

// ---- vectored_priority_interrupt_controller_tb.sv ----
module vectored_priority_interrupt_controller_tb
    import intc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, slow = 0, core_ready, return_req, twe = 0;
    logic [NUM_IRQ-1:0] irq_event = '0, flag_clear = '0, enable_bits = '0, request_flag_regs;
    logic [NUM_IRQ*PRI_W-1:0] pri = '0;
    logic [NUM_TRAP-1:0] trap_event = '0, trap_clear = '0, trap_flags;
    logic [LVL_W-1:0] lvl = '0, new_cpu_level;
    logic [VEC_W-1:0] twv = '0, accepted_vector_number;
    logic [ADDR_W-1:0] twa = '0, entry_addr, program_counter, pending_table_addr;
    logic core_irq, entry_valid, return_done, busy;
    int bad_count = 0, n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    vectored_priority_interrupt_controller uut (.clk_sys, .rst, .irq_event, .flag_clear, .enable_bits,
        .source_priority_regs(pri), .trap_event, .trap_clear, .cpu_priority_level(lvl), .core_ready, .return_req,
        .table_wr_en(twe), .table_wr_vector(twv), .table_wr_addr(twa), .core_irq, .entry_valid, .entry_addr,
        .return_done, .busy, .program_counter, .request_flag_regs, .trap_flags, .accepted_vector_number,
        .new_cpu_level, .pending_table_addr);
    core_model core (.clk_sys, .rst, .entry_valid, .return_done, .slow, .core_ready, .return_req);
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Software loads the table, one word per vector.
    task automatic load(input int v, input logic [23:0] a);
        @(negedge clk_sys);
        twe = 1;
        twv = v[7:0];
        twa = a;
        @(negedge clk_sys);
        twe = 0;
    endtask
    // Raises one or two source events for a single cycle, written as one assignment.
    task automatic fire(input int a, input int b);
        @(negedge clk_sys);
        irq_event = (NUM_IRQ'(1) << a) | (NUM_IRQ'(1) << b);
        @(negedge clk_sys);
        irq_event = '0;
    endtask
    // Waits for entry, checks what was latched, clears the source so it does not come back.
    // A wait that runs out counts as a mismatch.
    task automatic take(input int v, input int l, input logic [23:0] a);
        int k;
        k = 0;
        while (entry_valid !== 1'h1 && k < 60) begin
            @(posedge clk_sys);
            #1 k++;
        end
        if (k >= 60) bad_count++;
        chk("vector", 24'(v), {16'h0, accepted_vector_number});
        chk("level", 24'(l), {20'h0, new_cpu_level});
        chk("entry_addr", a, entry_addr);
        @(negedge clk_sys);
        if (v < 8) trap_clear[v] = 1;
        else flag_clear[v - 8] = 1;
        @(negedge clk_sys);
        {trap_clear, flag_clear} = '0;
        k = 0;
        while (busy !== 1'h0 && k < 60) begin
            @(negedge clk_sys);
            k++;
        end
        if (k >= 60) bad_count++;
    endtask
    initial begin
        #50us bad_count++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk("program_counter", 24'h0, program_counter);
        load(8, 24'h000200);
        load(11, 24'h000300);
        load(2, 24'h000400);
        enable_bits[0] = 1'b1;
        enable_bits[3] = 1'b1;
        enable_bits[15] = 1'b1;
        pri[2:0] = 3'h3;
        pri[11:9] = 3'h3;
        fire(0, 3);
        chk("table_addr", 24'h000014, pending_table_addr);
        take(8, 3, 24'h000200);
        chk("flag_held", 24'h1, {23'h0, request_flag_regs[3]});
        take(11, 3, 24'h000300);
        slow = 1'b1;
        pri[2:0] = 3'h2;
        pri[11:9] = 3'h5;
        fire(0, 3);
        take(11, 5, 24'h000300);
        take(8, 2, 24'h000200);
        lvl = 4'h5;
        fire(3, 3);
        chk("masked_irq", 24'h0, {23'h0, core_irq});
        lvl = 4'h4;
        take(11, 5, 24'h000300);
        lvl = 4'h8;
        pri[11:9] = 3'h7;
        fire(3, 3);
        chk("blocked_irq", 24'h0, {23'h0, core_irq});
        @(negedge clk_sys);
        trap_event[2] = 1'b1;
        @(negedge clk_sys);
        trap_event = '0;
        take(2, 15, 24'h000400);
        lvl = 4'h0;
        take(11, 7, 24'h000300);
        pri[2:0] = 3'h0;
        fire(0, 15);
        chk("zero_pri_irq", 24'h0, {23'h0, core_irq});
        chk("reserved_flag", 24'h0, {23'h0, request_flag_regs[15]});
        close_out;
    end
endmodule
